// ### inc/pwmcps_pkg.sv
// package: register map, field layout and constants of the pwm clock prescale and chop block
package pwmcps_pkg;
	// register byte addresses on the apb bus
	localparam logic [11:0] PWMCPS_ADDR_PRESCALE = 12'h000;
	localparam logic [11:0] PWMCPS_ADDR_CHOP     = 12'h004;
	localparam logic [11:0] PWMCPS_ADDR_DUTY     = 12'h008;
	localparam logic [11:0] PWMCPS_ADDR_CONTROL  = 12'h00c;
	localparam logic [11:0] PWMCPS_ADDR_STATUS   = 12'h010;
	// field layout
	localparam int PWMCPS_SEL_W      = 3;
	localparam int PWMCPS_CHOP_EN_B  = 15;
	localparam int PWMCPS_CHOP_DIV_W = 10;
	localparam int PWMCPS_DUTY_W     = 16;
	localparam int PWMCPS_CTRL_TB_B  = 0;
	// reset values
	localparam logic [2:0]  PWMCPS_SEL_RST      = 3'h0;
	localparam logic [15:0] PWMCPS_CHOP_RST     = 16'h0000;
	localparam logic [15:0] PWMCPS_DUTY_RST     = 16'h0000;
	// reserved select code
	localparam logic [2:0]  PWMCPS_SEL_RESERVED = 3'h7;
	// prescale counter width: divide-by-64 needs six bits
	localparam int PWMCPS_PRE_W = 6;
	typedef enum logic [1:0] {
		PWMCPS_CHOP_IDLE,
		PWMCPS_CHOP_RUN
	} pwmcps_chop_state_t;
endpackage : pwmcps_pkg

// ### core/pwmcps_prescaler.sv
// prescaler: one-cycle enable pulse at pclk divided by 2^select, or by 64 for reserved code 111
`timescale 1ns/100ps
`default_nettype none
module pwmcps_prescaler (
	// clock and reset
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	// control
	input  wire logic [pwmcps_pkg::PWMCPS_SEL_W-1:0] sel,
	// output enable pulse
	output logic                                  tick
);
	import pwmcps_pkg::*;

	logic [PWMCPS_PRE_W-1:0] cnt_q;
	logic [PWMCPS_PRE_W-1:0] cnt_d;
	logic [PWMCPS_PRE_W-1:0] term;

	always_comb begin
		// code 111 has no ratio; treated as divide-by-64 so the counter stays bounded
		if (sel == PWMCPS_SEL_RESERVED) begin
			term = '1;
		end else begin
			term = PWMCPS_PRE_W'((7'h01 << sel) - 7'h01);
		end
		tick  = (cnt_q >= term);
		cnt_d = tick ? '0 : cnt_q + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : pwmcps_prescaler
`default_nettype wire

// ### core/pwmcps_top.sv
// top: apb registers, prescaler, chop clock generator and master duty value
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pwmcps_top (
	// clock and reset
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	// apb slave
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [11:0]                           paddr,
	input  wire logic [31:0]                           pwdata,
	input  wire logic [3:0]                            pstrb,
	output logic                                       pready,
	output logic [31:0]                                prdata,
	output logic                                       pslverr,
	// to pwm channels
	output logic                                       pwm_timebase_enable,
	output logic                                       prescaled_tick,
	output logic                                       chop_clock,
	output logic                                       chop_tick,
	output logic [pwmcps_pkg::PWMCPS_DUTY_W-1:0]       master_duty_value
);
	import pwmcps_pkg::*;

	// registers
	logic [PWMCPS_SEL_W-1:0]      sel_q, sel_d;
	logic                         chop_en_q, chop_en_d;
	logic [PWMCPS_CHOP_DIV_W-1:0] chop_div_q, chop_div_d;
	logic [PWMCPS_DUTY_W-1:0]     duty_q, duty_d;
	logic                         tb_q, tb_d;
	logic [31:0]                  rdata_q, rdata_d;
	logic                         ready_q, ready_d;
	logic                         err_q, err_d;
	// chop generator state
	pwmcps_chop_state_t           st_q, st_d;
	logic [PWMCPS_CHOP_DIV_W-1:0] ccnt_q, ccnt_d;
	logic                         cout_q, cout_d;
	logic                         ctick_q, ctick_d;
	logic                         pre_tick_q;
	logic                         pre_tick;
	logic                         setup;
	logic                         acc_done;
	logic                         wr_lo;
	logic                         wr_hi;
	logic                         mapped;
	logic [15:0]                  wval;

	pwmcps_prescaler u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.sel     (sel_q),
		.tick    (pre_tick)
	);

	// answer one cycle after setup: pready rises with penable, no wait states
	assign setup    = psel && !penable;
	// writes land only at the edge that completes the transfer, never at setup
	assign acc_done = psel && penable && ready_q;
	assign wr_lo    = acc_done && pwrite && pstrb[0];
	assign wr_hi    = acc_done && pwrite && pstrb[1];

	always_comb begin
		mapped = (paddr == PWMCPS_ADDR_PRESCALE) || (paddr == PWMCPS_ADDR_CHOP) ||
			(paddr == PWMCPS_ADDR_DUTY) || (paddr == PWMCPS_ADDR_CONTROL) ||
			(paddr == PWMCPS_ADDR_STATUS);
		wval       = pwdata[15:0];
		sel_d      = sel_q;
		chop_en_d  = chop_en_q;
		chop_div_d = chop_div_q;
		duty_d     = duty_q;
		tb_d       = tb_q;
		rdata_d    = rdata_q;
		ready_d    = setup;
		err_d      = setup && !mapped;
		// writes at the access edge; read data registered at setup so it stands in the access cycle
		if (wr_lo && paddr == PWMCPS_ADDR_PRESCALE) begin
			sel_d = wval[PWMCPS_SEL_W-1:0];
		end
		if (paddr == PWMCPS_ADDR_CHOP) begin
			if (wr_lo) begin
				chop_div_d[7:0] = wval[7:0];
			end
			if (wr_hi) begin
				chop_div_d[PWMCPS_CHOP_DIV_W-1:8] = wval[PWMCPS_CHOP_DIV_W-1:8];
				chop_en_d = wval[PWMCPS_CHOP_EN_B];
			end
		end
		if (paddr == PWMCPS_ADDR_DUTY) begin
			if (wr_lo) begin
				duty_d[7:0] = wval[7:0];
			end
			if (wr_hi) begin
				duty_d[15:8] = wval[15:8];
			end
		end
		if (wr_lo && paddr == PWMCPS_ADDR_CONTROL) begin
			tb_d = wval[PWMCPS_CTRL_TB_B];
		end
		if (setup && !pwrite) begin
			rdata_d = '0;
			case (paddr)
				PWMCPS_ADDR_PRESCALE: rdata_d[PWMCPS_SEL_W-1:0] = sel_q;
				PWMCPS_ADDR_CHOP: begin
					rdata_d[PWMCPS_CHOP_EN_B]           = chop_en_q;
					rdata_d[PWMCPS_CHOP_DIV_W-1:0]      = chop_div_q;
				end
				PWMCPS_ADDR_DUTY:     rdata_d[PWMCPS_DUTY_W-1:0] = duty_q;
				PWMCPS_ADDR_CONTROL:  rdata_d[PWMCPS_CTRL_TB_B]  = tb_q;
				PWMCPS_ADDR_STATUS: begin
					rdata_d[0] = cout_q;
					rdata_d[1] = (st_q == PWMCPS_CHOP_RUN);
					rdata_d[PWMCPS_CHOP_DIV_W+1:2] = ccnt_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	// chop generator: counts prescaled ticks 0..divider, toggles output at each wrap
	always_comb begin
		st_d    = st_q;
		ccnt_d  = ccnt_q;
		cout_d  = cout_q;
		ctick_d = 1'b0;
		case (st_q)
			PWMCPS_CHOP_IDLE: begin
				ccnt_d = '0;
				cout_d = 1'b0;
				if (chop_en_q) begin
					st_d = PWMCPS_CHOP_RUN;
				end
			end
			PWMCPS_CHOP_RUN: begin
				if (!chop_en_q) begin
					st_d = PWMCPS_CHOP_IDLE;
				end else if (pre_tick) begin
					// a divider lowered below the count wraps at once, no long rollover
					if (ccnt_q >= chop_div_q) begin
						ccnt_d  = '0;
						ctick_d = 1'b1;
						cout_d  = !cout_q;
					end else begin
						ccnt_d = ccnt_q + 1'b1;
					end
				end
			end
			default: st_d = PWMCPS_CHOP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q      <= PWMCPS_SEL_RST;
			chop_en_q  <= PWMCPS_CHOP_RST[PWMCPS_CHOP_EN_B];
			chop_div_q <= PWMCPS_CHOP_RST[PWMCPS_CHOP_DIV_W-1:0];
			duty_q     <= PWMCPS_DUTY_RST;
			tb_q       <= 1'b0;
			rdata_q    <= '0;
			ready_q    <= 1'b0;
			err_q      <= 1'b0;
			st_q       <= PWMCPS_CHOP_IDLE;
			ccnt_q     <= '0;
			cout_q     <= 1'b0;
			ctick_q    <= 1'b0;
			pre_tick_q <= 1'b0;
		end else begin
			sel_q      <= sel_d;
			chop_en_q  <= chop_en_d;
			chop_div_q <= chop_div_d;
			duty_q     <= duty_d;
			tb_q       <= tb_d;
			rdata_q    <= rdata_d;
			ready_q    <= ready_d;
			err_q      <= err_d;
			st_q       <= st_d;
			ccnt_q     <= ccnt_d;
			cout_q     <= cout_d;
			ctick_q    <= ctick_d;
			pre_tick_q <= pre_tick;
		end
	end

	assign pready              = ready_q;
	assign prdata              = rdata_q;
	assign pslverr             = err_q;
	assign pwm_timebase_enable = tb_q;
	assign prescaled_tick      = pre_tick_q;
	assign chop_clock          = cout_q;
	assign chop_tick           = ctick_q;
	assign master_duty_value   = duty_q;
endmodule : pwmcps_top
`default_nettype wire

// ### verification/pwmcps_properties.sv
// checker: port timing of the pwm clock prescale and chop block
`timescale 1ns/100ps
`default_nettype none
module pwmcps_properties
	import pwmcps_pkg::*;
(
	// clock, reset and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	// pwm side
	input wire logic        prescaled_tick,
	input wire logic        chop_clock,
	input wire logic        chop_tick,
	input wire logic [15:0] master_duty_value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite && pready;
	wire rd = psel && penable && !pwrite && pready;
	a_ready_pulse: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_duty_write: assert property (wr && paddr == PWMCPS_ADDR_DUTY && pstrb[1:0] == 2'h3
		|=> master_duty_value == $past(pwdata[15:0])) else $error("duty not written");
	a_duty_hold: assert property ($changed(master_duty_value)
		|-> $past(wr) && $past(paddr) == PWMCPS_ADDR_DUTY) else $error("duty changed alone");
	a_sel_read: assert property (rd && paddr == PWMCPS_ADDR_PRESCALE |-> prdata[31:3] == '0)
		else $error("select upper bits set");
	a_chop_read: assert property (rd && paddr == PWMCPS_ADDR_CHOP
		|-> prdata[31:16] == '0 && prdata[14:10] == '0) else $error("chop gap bits set");
	a_chop_toggle: assert property (chop_tick |-> $changed(chop_clock)) else $error("wrap without toggle");
	a_chop_stop: assert property (wr && paddr == PWMCPS_ADDR_CHOP && pstrb[1] && !pwdata[15]
		|=> ##2 (!chop_clock && !chop_tick)[*3]) else $error("chop runs while off");
	a_tick_div1: assert property (wr && paddr == PWMCPS_ADDR_PRESCALE && pstrb[0] && pwdata[2:0] == 3'h0
		|=> ##3 prescaled_tick[*4]) else $error("divide by one not steady");
endmodule : pwmcps_properties
bind pwmcps_top pwmcps_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .pready, .prdata, .prescaled_tick, .chop_clock, .chop_tick, .master_duty_value);
`default_nettype wire

// ### verification/tb_top.sv
// testbench: registers, prescale ratios and chop rate of the pwm clock block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import pwmcps_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, err, tb_en, ptick, chop_clock, chop_tick;
	logic [15:0] duty;
	int          miscompares = 0, num_checks = 0, cyc = 0, n;
	always #25 pclk = ~pclk;
	pwmcps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pwm_timebase_enable(tb_en), .prescaled_tick(ptick), .chop_clock(chop_clock),
		.chop_tick(chop_tick), .master_duty_value(duty));
	task automatic finish_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	// a hang is cut short well above the longest chop period sequence
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// skips the first two ticks so a counter left over from the old setting is not measured
	task automatic gap(input bit c, output int g);
		repeat (2) do @(posedge pclk); while ((c ? chop_tick : ptick) !== 1'b1);
		g = 0;
		do begin
			@(posedge pclk);
			g++;
		end while ((c ? chop_tick : ptick) !== 1'b1);
	endtask : gap
	task automatic t_regs();
		apb(0, PWMCPS_ADDR_PRESCALE, 0);
		chk("sel_rst", rd, 0);
		apb(0, PWMCPS_ADDR_DUTY, 0);
		chk("duty_rst0", rd, 0);
		apb(0, PWMCPS_ADDR_CHOP, 0);
		chk("chop_rst", rd, 0);
		apb(1, PWMCPS_ADDR_DUTY, 32'hffffffff);
		apb(0, PWMCPS_ADDR_DUTY, 0);
		chk("duty_rd", rd, 32'h0000ffff);
		chk("duty_out", duty, 32'h0000ffff);
		pstrb <= 4'h1;
		apb(1, PWMCPS_ADDR_DUTY, 32'h00001234);
		pstrb <= 4'hf;
		apb(0, PWMCPS_ADDR_DUTY, 0);
		chk("duty_lane", rd, 32'h0000ff34);
		apb(1, PWMCPS_ADDR_PRESCALE, 32'hfffffff8);
		apb(0, PWMCPS_ADDR_PRESCALE, 0);
		chk("sel_rd", rd, 0);
		apb(1, PWMCPS_ADDR_CHOP, 32'h00007c00);
		apb(0, PWMCPS_ADDR_CHOP, 0);
		chk("chop_rd", rd, 0);
		chk("mapped_err", err, 0);
		apb(1, 12'h020, 32'h1);
		chk("unmapped", err, 1);
		$display("test regs done");
	endtask : t_regs
	task automatic t_prescale();
		// timebase stays off while the ratio changes and code 111 is never written
		for (int s = 0; s < 7; s++) begin
			apb(1, PWMCPS_ADDR_PRESCALE, s);
			gap(0, n);
			chk("tick_gap", n, 1 << s);
		end
		$display("test prescale done");
	endtask : t_prescale
	task automatic chop_case(input int s, input int d);
		apb(1, PWMCPS_ADDR_PRESCALE, s);
		apb(1, PWMCPS_ADDR_CHOP, 32'h8000 | d);
		gap(1, n);
		chk("chop_gap", n, (d + 1) << s);
	endtask : chop_case
	task automatic t_chop();
		chop_case(1, 3);
		chop_case(2, 0);
		chop_case(0, 10'h3ff);
		apb(1, PWMCPS_ADDR_CHOP, 3);
		repeat (3) @(posedge pclk);
		repeat (20) begin
			@(posedge pclk);
			chk("chop_off", chop_clock | chop_tick, 0);
		end
		apb(1, PWMCPS_ADDR_CONTROL, 1);
		@(posedge pclk);
		chk("tb_en", tb_en, 1);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, PWMCPS_ADDR_DUTY, 0);
		chk("duty_rst", rd, 0);
		$display("test chop done");
	endtask : t_chop
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_prescale();
		t_chop();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
